//--- rtl/irtcg_carrier.sv
// carrier counter alternating low and high widths
`timescale 1ns/10ps
module irtcg_carrier (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // control
  input wire logic start,
  input wire logic run,
  input wire logic [8:0] highWidth,
  input wire logic [8:0] lowWidth,
  // carrier
  output logic level,
  output logic active
);
  irtcg_pkg::irtcg_car_state_t state, next_state;
  logic [8:0] cnt;
  logic [8:0] next_cnt;
  logic terminal;

  assign terminal = (cnt == 9'h000);
  assign level = (state == irtcg_pkg::CAR_HIGH);
  assign active = (state != irtcg_pkg::CAR_IDLE);

  always_comb begin
    next_state = state;
    next_cnt = 9'(cnt - 9'h001);
    unique case (state)
      irtcg_pkg::CAR_IDLE: begin
        next_cnt = cnt;
      end
      irtcg_pkg::CAR_LOW: begin
        if (!run) begin
          next_state = irtcg_pkg::CAR_IDLE;
        end else if (terminal) begin
          next_state = irtcg_pkg::CAR_HIGH;
          next_cnt = highWidth;
        end
      end
      irtcg_pkg::CAR_HIGH: begin
        if (terminal) begin
          // high phase always completes before the carrier stops
          next_state = run ? irtcg_pkg::CAR_LOW : irtcg_pkg::CAR_IDLE;
          next_cnt = lowWidth;
        end
      end
      default: begin
        next_state = irtcg_pkg::CAR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state <= irtcg_pkg::CAR_IDLE;
      cnt <= 9'h000;
    end else if (start) begin
      state <= irtcg_pkg::CAR_LOW;
      cnt <= lowWidth;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end
endmodule : irtcg_carrier

//--- rtl/irtcg_down_timer.sv
// 9-bit burst down counter with its prescaler and zero detector
`timescale 1ns/10ps
module irtcg_down_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // load from the cpu, and the variant select
  input wire logic load,
  input wire logic [8:0] loadValue,
  input wire logic fastVariant,
  // state
  output logic [8:0] count,
  output logic zero
);
  logic [7:0] prescale;
  logic tick;
  logic [7:0] next_prescale;
  logic [8:0] next_count;

  assign zero = (count == 9'h000);
  assign tick = (prescale == 8'h00);
  assign next_prescale = tick ? irtcg_pkg::PRE_RELOAD : 8'(prescale - 8'h01);
  assign next_count = tick ? 9'(count - 9'h001) : count;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      count <= 9'h000;
      prescale <= 8'h00;
    end else if (load) begin
      // first interval is stretched so the burst lasts value + 1 (or + 0.5) ticks
      count <= loadValue;
      prescale <= fastVariant ? irtcg_pkg::PRE_FIRST_FAST : irtcg_pkg::PRE_FIRST_NORM;
    end else if (!zero) begin
      count <= next_count;
      prescale <= next_prescale;
    end
  end
endmodule : irtcg_down_timer

//--- rtl/irtcg_pkg.sv
// shared constants, types and helpers for the ir timer and carrier generator
package irtcg_pkg;
  // timing: mclk 100 MHz stands for twice the oscillator rate
  localparam int CLK_NS = 10;
  localparam int OSC_NS = 20;
  localparam int TICK_OSC = 64;
  localparam int TICK_NS = TICK_OSC * OSC_NS;
  localparam int TICK_CLKS = TICK_NS / CLK_NS;
  localparam logic [7:0] PRE_RELOAD = 8'(TICK_CLKS - 1);
  localparam logic [7:0] PRE_FIRST_NORM = 8'(2 * TICK_CLKS - 1);
  localparam logic [7:0] PRE_FIRST_FAST = 8'(TICK_CLKS + TICK_CLKS / 2 - 1);

  // widths and field positions
  localparam int COUNT_W = 9;
  localparam int REG_W = 10;
  localparam int NIB_W = 4;
  localparam int TIMER_OUTPUT_ENABLE_BIT = 9;
  localparam int CARRIER_DISABLE_BIT = 9;

  // reset values
  localparam logic [9:0] TIMER_RESET = 10'h000;
  localparam logic [9:0] HIGH_WIDTH_RESET = 10'h000;
  localparam logic [8:0] LOW_WIDTH_RESET = 9'h000;

  // status-test operand that checks the down counter for zero
  localparam logic [3:0] STATUS_TIMER_ZERO = 4'h5;

  typedef enum logic [2:0] {
    OP_WRNIB = 3'b001,
    OP_WR10 = 3'b010,
    OP_RD = 3'b100
  } irtcg_op_t;

  typedef enum logic [2:0] {
    SEL_TIMER = 3'b001,
    SEL_HIGH = 3'b010,
    SEL_LOW = 3'b100
  } irtcg_sel_t;

  typedef enum logic [2:0] {
    CAR_IDLE = 3'b001,
    CAR_LOW = 3'b010,
    CAR_HIGH = 3'b100
  } irtcg_car_state_t;

  typedef struct packed {
    logic valid;
    irtcg_op_t op;
    irtcg_sel_t sel;
    logic [1:0] nib;
    logic [9:0] data;
  } irtcg_cmd_t;

  typedef struct packed {
    logic valid;
    logic [9:0] word;
    logic [3:0] nibble;
  } irtcg_rd_t;

  // nibble 2 holds bits 9:8 in its low two bits
  function automatic logic [9:0] nib_write(input logic [9:0] old, input logic [1:0] nib,
                                           input logic [3:0] d);
    logic [9:0] r;
    r = old;
    case (nib)
      2'h0: r[3:0] = d;
      2'h1: r[7:4] = d;
      default: r[9:8] = d[1:0];
    endcase
    return r;
  endfunction : nib_write

  function automatic logic [3:0] nib_read(input logic [9:0] w, input logic [1:0] nib);
    logic [3:0] r;
    case (nib)
      2'h0: r = w[3:0];
      2'h1: r = w[7:4];
      default: r = {2'h0, w[9:8]};
    endcase
    return r;
  endfunction : nib_read
endpackage : irtcg_pkg

//--- rtl/irtcg_top.sv
// ir burst timer and carrier generator, top level
`timescale 1ns/10ps
module irtcg_top #(
  parameter bit FAST_VARIANT = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // timer manipulation from the cpu
  input wire irtcg_pkg::irtcg_cmd_t cmd,
  output irtcg_pkg::irtcg_rd_t rd,
  // status test and halt
  input wire logic statusTestValid,
  input wire logic [3:0] statusOperand,
  output logic statusFlag,
  input wire logic haltWaitTimer,
  output logic haltRelease,
  output logic endOfOperation,
  // pins
  output logic irOutput,
  output logic txIndicator_b
);
  // register storage
  logic timerOutputEnable;
  logic [9:0] highWidthModulo;
  logic [8:0] lowWidthModulo;

  // timer and carrier state
  logic [8:0] downCount;
  logic timerZero;
  logic carrierLevel;
  logic carrierActive;

  // command decode
  logic isWrite;
  logic isRead;
  logic wrTimer;
  logic wrHigh;
  logic wrLow;
  logic [9:0] timerWord;
  logic [9:0] lowWord;
  logic [9:0] selWord;
  logic [9:0] next_timerWord;
  logic [9:0] next_highWord;
  logic [9:0] next_lowWord;
  logic timerLoad;
  logic carrierStart;
  logic carrierDisable;
  logic timerRunning;
  logic next_irOutput;
  logic next_txIndicator_b;
  logic statusHit;

  assign isWrite = cmd.valid && (cmd.op == irtcg_pkg::OP_WRNIB || cmd.op == irtcg_pkg::OP_WR10);
  assign isRead = cmd.valid && (cmd.op == irtcg_pkg::OP_RD);
  assign wrTimer = isWrite && (cmd.sel == irtcg_pkg::SEL_TIMER);
  assign wrHigh = isWrite && (cmd.sel == irtcg_pkg::SEL_HIGH);
  assign wrLow = isWrite && (cmd.sel == irtcg_pkg::SEL_LOW);

  assign timerWord = {timerOutputEnable, downCount};
  assign lowWord = {1'b0, lowWidthModulo};

  // word write replaces all ten bits (nine kept for the low width), nibble write merges one field
  assign next_timerWord = (cmd.op == irtcg_pkg::OP_WR10) ? cmd.data
                        : irtcg_pkg::nib_write(timerWord, cmd.nib, cmd.data[3:0]);
  assign next_highWord = (cmd.op == irtcg_pkg::OP_WR10) ? cmd.data
                       : irtcg_pkg::nib_write(highWidthModulo, cmd.nib, cmd.data[3:0]);
  assign next_lowWord = (cmd.op == irtcg_pkg::OP_WR10) ? cmd.data
                      : irtcg_pkg::nib_write(lowWord, cmd.nib, cmd.data[3:0]);

  assign selWord = (cmd.sel == irtcg_pkg::SEL_TIMER) ? timerWord
                 : (cmd.sel == irtcg_pkg::SEL_HIGH) ? highWidthModulo
                 : lowWord;

  // any timer load restarts the burst; a zero value simply stops it
  assign timerLoad = wrTimer;
  assign carrierDisable = highWidthModulo[irtcg_pkg::CARRIER_DISABLE_BIT];
  assign carrierStart = timerLoad && (next_timerWord[8:0] != 9'h000) && !carrierDisable;
  assign timerRunning = !timerZero;

  irtcg_down_timer u_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .load(timerLoad),
    .loadValue(next_timerWord[8:0]),
    .fastVariant(FAST_VARIANT),
    .count(downCount),
    .zero(timerZero)
  );

  // carrier counter is clocked every mclk, which is twice the oscillator rate
  irtcg_carrier u_carrier (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(carrierStart),
    .run(timerRunning),
    .highWidth(highWidthModulo[8:0]),
    .lowWidth(lowWidthModulo),
    .level(carrierLevel),
    .active(carrierActive)
  );

  // end of operation and halt release
  assign endOfOperation = timerZero;
  assign haltRelease = haltWaitTimer && timerZero;
  assign statusHit = statusTestValid && (statusOperand == irtcg_pkg::STATUS_TIMER_ZERO);

  // pin levels
  assign next_irOutput = timerOutputEnable
                       && (carrierDisable ? timerRunning : carrierLevel);
  assign next_txIndicator_b = !(timerOutputEnable && timerRunning);

  // register writes
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      timerOutputEnable <= irtcg_pkg::TIMER_RESET[irtcg_pkg::TIMER_OUTPUT_ENABLE_BIT];
      highWidthModulo <= irtcg_pkg::HIGH_WIDTH_RESET;
      lowWidthModulo <= irtcg_pkg::LOW_WIDTH_RESET;
    end else begin
      if (wrTimer) begin
        timerOutputEnable <= next_timerWord[irtcg_pkg::TIMER_OUTPUT_ENABLE_BIT];
      end
      if (wrHigh) begin
        highWidthModulo <= next_highWord;
      end
      if (wrLow) begin
        lowWidthModulo <= next_lowWord[8:0];
      end
    end
  end

  // read data
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rd <= '0;
    end else begin
      rd.valid <= isRead;
      if (isRead) begin
        rd.word <= selWord;
        rd.nibble <= irtcg_pkg::nib_read(selWord, cmd.nib);
      end
    end
  end

  // status flag
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      statusFlag <= 1'b0;
    end else if (statusHit) begin
      statusFlag <= timerZero;
    end
  end

  // pins
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irOutput <= 1'b0;
      txIndicator_b <= 1'b1;
    end else begin
      irOutput <= next_irOutput;
      txIndicator_b <= next_txIndicator_b;
    end
  end

  // helper: cycles since the last count step, for the step spacing check
  logic [7:0] sinceStep;
  logic firstStep;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sinceStep <= 8'h00;
      firstStep <= 1'b0;
    end else if (timerLoad) begin
      sinceStep <= 8'h00;
      firstStep <= 1'b1;
    end else if (downCount != u_timer.next_count && !timerZero && u_timer.tick) begin
      sinceStep <= 8'h00;
      firstStep <= 1'b0;
    end else begin
      sinceStep <= 8'(sinceStep + 8'h01);
    end
  end

  // helper: length of the current carrier phase
  logic [9:0] phaseLen;
  logic carrierLevelDly;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      phaseLen <= 10'h000;
      carrierLevelDly <= 1'b0;
    end else begin
      carrierLevelDly <= carrierLevel;
      phaseLen <= (carrierLevel != carrierLevelDly || carrierStart) ? 10'h001
                : 10'(phaseLen + 10'h001);
    end
  end

  property p_zero_holds;
    @(posedge mclk) disable iff (!rst_b)
    (timerZero && !timerLoad) |=> (timerZero && endOfOperation);
  endproperty
  a_zero_holds: assert property (p_zero_holds)
    else $error("down counter left zero without a load");

  property p_end_tracks_zero;
    @(posedge mclk) disable iff (!rst_b)
    endOfOperation == (downCount == 9'h000);
  endproperty
  a_end_tracks_zero: assert property (p_end_tracks_zero)
    else $error("end signal disagrees with counter");

  property p_load_starts;
    @(posedge mclk) disable iff (!rst_b)
    (timerLoad && next_timerWord[8:0] != 9'h000) |=> !endOfOperation [*8];
  endproperty
  a_load_starts: assert property (p_load_starts)
    else $error("nonzero load did not start the timer");

  property p_step_by_one;
    @(posedge mclk) disable iff (!rst_b)
    (!timerLoad && !timerZero) |=>
      (downCount == $past(downCount)) || (downCount == 9'($past(downCount) - 9'h001));
  endproperty
  a_step_by_one: assert property (p_step_by_one)
    else $error("down counter moved by other than one");

  property p_step_spacing;
    @(posedge mclk) disable iff (!rst_b)
    (!timerLoad && !timerZero && u_timer.tick && !firstStep)
      |-> (sinceStep == irtcg_pkg::PRE_RELOAD);
  endproperty
  a_step_spacing: assert property (p_step_spacing)
    else $error("count step spacing wrong");

  property p_first_interval;
    @(posedge mclk) disable iff (!rst_b)
    (!timerLoad && !timerZero && u_timer.tick && firstStep)
      |-> (sinceStep == (FAST_VARIANT ? irtcg_pkg::PRE_FIRST_FAST : irtcg_pkg::PRE_FIRST_NORM));
  endproperty
  a_first_interval: assert property (p_first_interval)
    else $error("first count interval wrong");

  property p_halt_release;
    @(posedge mclk) disable iff (!rst_b)
    (haltWaitTimer && endOfOperation) |-> haltRelease;
  endproperty
  a_halt_release: assert property (p_halt_release)
    else $error("halt not released at timer end");

  property p_indicator;
    @(posedge mclk) disable iff (!rst_b)
    (timerOutputEnable && !timerZero && !wrTimer) |=> !txIndicator_b;
  endproperty
  a_indicator: assert property (p_indicator)
    else $error("indicator not low while running");

  property p_steady_high;
    @(posedge mclk) disable iff (!rst_b)
    (timerOutputEnable && carrierDisable && !timerZero) |=> irOutput;
  endproperty
  a_steady_high: assert property (p_steady_high)
    else $error("ir output not steady high");

  property p_disabled_low;
    @(posedge mclk) disable iff (!rst_b)
    !timerOutputEnable |=> !irOutput;
  endproperty
  a_disabled_low: assert property (p_disabled_low)
    else $error("ir output high while disabled");

  property p_zero_low_steady;
    @(posedge mclk) disable iff (!rst_b)
    (timerZero && carrierDisable) |=> !irOutput;
  endproperty
  a_zero_low_steady: assert property (p_zero_low_steady)
    else $error("ir output high with counter zero");

  property p_low_first;
    @(posedge mclk) disable iff (!rst_b)
    carrierStart |=> (carrierActive && !carrierLevel) ##1 !irOutput;
  endproperty
  a_low_first: assert property (p_low_first)
    else $error("carrier did not open with low phase");

  property p_high_completes;
    @(posedge mclk) disable iff (!rst_b)
    (carrierLevel && !carrierStart && u_carrier.cnt != 9'h000 && $fell(timerRunning))
      |=> carrierLevel;
  endproperty
  a_high_completes: assert property (p_high_completes)
    else $error("high phase cut short at timer end");

  property p_idle_after_zero;
    @(posedge mclk) disable iff (!rst_b)
    ($rose(timerZero) && !carrierLevel && !carrierStart) |-> ##1 !carrierActive;
  endproperty
  a_idle_after_zero: assert property (p_idle_after_zero)
    else $error("carrier still active after timer end");

  property p_high_width;
    @(posedge mclk) disable iff (!rst_b)
    ($fell(carrierLevel) && !$past(carrierStart))
      |-> (phaseLen == 10'({1'b0, highWidthModulo[8:0]} + 10'h001));
  endproperty
  a_high_width: assert property (p_high_width)
    else $error("high half-period length wrong");

  property p_toggle;
    @(posedge mclk) disable iff (!rst_b)
    (carrierActive && !carrierStart && timerRunning && u_carrier.cnt == 9'h000)
      |=> (carrierLevel != $past(carrierLevel));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("carrier did not toggle at terminal count");

  property p_low_bit9;
    @(posedge mclk) disable iff (!rst_b)
    (isRead && cmd.sel == irtcg_pkg::SEL_LOW) |=> !rd.word[9];
  endproperty
  a_low_bit9: assert property (p_low_bit9)
    else $error("low width bit 9 read as one");

  property p_status;
    @(posedge mclk) disable iff (!rst_b)
    statusHit |=> (statusFlag == $past(timerZero));
  endproperty
  a_status: assert property (p_status)
    else $error("status flag does not reflect counter zero");

  property p_readback;
    @(posedge mclk) disable iff (!rst_b)
    (wrHigh && cmd.op == irtcg_pkg::OP_WR10) ##1 !wrHigh ##1
      (isRead && cmd.sel == irtcg_pkg::SEL_HIGH)
      |=> (rd.word == $past(cmd.data, 3));
  endproperty
  a_readback: assert property (p_readback)
    else $error("high width readback mismatch");
endmodule : irtcg_top

//--- tb/ir_timer_carrier_generator_bench.sv
// self-checking bench for the ir burst timer and carrier generator
`timescale 1ns/10ps
module ir_timer_carrier_generator_bench;
  typedef struct {
    irtcg_pkg::irtcg_op_t op;
    irtcg_pkg::irtcg_sel_t sel;
    logic [1:0] nib;
    logic [9:0] d;
    logic [1:0] rnib;
    logic [9:0] word;
    logic [3:0] nibv;
  } irtcg_row_t;

  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  irtcg_pkg::irtcg_cmd_t cmd;
  irtcg_pkg::irtcg_rd_t rd;
  logic statusTestValid, statusFlag, haltWaitTimer, haltRelease;
  logic endOfOperation, irOutput, txIndicator_b, stalled, prev, fastEnd;
  logic [3:0] statusOperand;
  int fails = 0;
  int nCompared = 0;
  int lowN, irN, ledN, relN, fastN, run, highs, lows;
  irtcg_row_t rows [8];

  always #5 mclk = ~mclk;

  irtcg_top #(.FAST_VARIANT(1'b0)) i_dut (
    .mclk(mclk), .rst_b(rst_b), .cmd(cmd), .rd(rd),
    .statusTestValid(statusTestValid), .statusOperand(statusOperand),
    .statusFlag(statusFlag), .haltWaitTimer(haltWaitTimer), .haltRelease(haltRelease),
    .endOfOperation(endOfOperation), .irOutput(irOutput), .txIndicator_b(txIndicator_b)
  );

  // high-speed variant fed the same instructions, only its end signal watched
  irtcg_top #(.FAST_VARIANT(1'b1)) i_fast (
    .mclk(mclk), .rst_b(rst_b), .cmd(cmd), .rd(),
    .statusTestValid(statusTestValid), .statusOperand(statusOperand),
    .statusFlag(), .haltWaitTimer(haltWaitTimer), .haltRelease(),
    .endOfOperation(fastEnd), .irOutput(), .txIndicator_b()
  );

  irtcg_cpu_model cpu (
    .mclk(mclk), .irOutput(irOutput), .cmd(cmd), .statusTestValid(statusTestValid),
    .statusOperand(statusOperand), .haltWaitTimer(haltWaitTimer), .stalled(stalled)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  initial begin
    rows = '{
      '{irtcg_pkg::OP_WR10, irtcg_pkg::SEL_HIGH, 2'h0, 10'h3A5, 2'h1, 10'h3A5, 4'hA},
      '{irtcg_pkg::OP_WR10, irtcg_pkg::SEL_LOW, 2'h0, 10'h3FF, 2'h2, 10'h1FF, 4'h1},
      '{irtcg_pkg::OP_WRNIB, irtcg_pkg::SEL_LOW, 2'h2, 10'h003, 2'h2, 10'h1FF, 4'h1},
      '{irtcg_pkg::OP_WRNIB, irtcg_pkg::SEL_LOW, 2'h0, 10'h006, 2'h0, 10'h1F6, 4'h6},
      '{irtcg_pkg::OP_WRNIB, irtcg_pkg::SEL_HIGH, 2'h2, 10'h001, 2'h2, 10'h1A5, 4'h1},
      '{irtcg_pkg::OP_WRNIB, irtcg_pkg::SEL_HIGH, 2'h1, 10'h00C, 2'h1, 10'h1C5, 4'hC},
      '{irtcg_pkg::OP_WR10, irtcg_pkg::SEL_TIMER, 2'h0, 10'h000, 2'h0, 10'h000, 4'h0},
      '{irtcg_pkg::OP_WRNIB, irtcg_pkg::SEL_TIMER, 2'h2, 10'h002, 2'h2, 10'h200, 4'h2}
    };
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    check({endOfOperation, irOutput, txIndicator_b, statusFlag}, 4'hA);
    for (int s = 0; s < 3; s++) begin
      cpu.issue(irtcg_pkg::OP_RD, irtcg_pkg::irtcg_sel_t'(3'b001 << s), 2'h0, 10'h000);
      @(negedge mclk);
      check(rd.word, 10'h000);
    end
    foreach (rows[i]) begin
      cpu.issue(rows[i].op, rows[i].sel, rows[i].nib, rows[i].d);
      cpu.issue(irtcg_pkg::OP_RD, rows[i].sel, rows[i].rnib, 10'h000);
      @(negedge mclk);
      check({rd.valid, rd.nibble, rd.word}, {1'b1, rows[i].nibv, rows[i].word});
    end
    // steady burst, carrier off, cpu halted on the timer
    cpu.issue(irtcg_pkg::OP_WR10, irtcg_pkg::SEL_HIGH, 2'h0, 10'h200);
    cpu.set_halt(1'b1);
    cpu.issue(irtcg_pkg::OP_WR10, irtcg_pkg::SEL_TIMER, 2'h0, 10'h203);
    lowN = 0;
    irN = 0;
    ledN = 0;
    relN = 0;
    fastN = 0;
    fork
      for (int i = 0; i < 1000; i++) begin
        @(negedge mclk);
        lowN += int'(endOfOperation === 1'b0);
        irN += int'(irOutput === 1'b1);
        ledN += int'(txIndicator_b === 1'b0);
        relN += int'(haltRelease === 1'b1);
        fastN += int'(fastEnd === 1'b0);
      end
      begin
        repeat (20) @(posedge mclk);
        cpu.status(irtcg_pkg::STATUS_TIMER_ZERO);
        @(negedge mclk);
        check(statusFlag, 1'b0);
      end
    join
    check(16'(lowN), 16'(4 * irtcg_pkg::TICK_CLKS));
    check(16'(irN), 16'(4 * irtcg_pkg::TICK_CLKS));
    check(16'(ledN), 16'(4 * irtcg_pkg::TICK_CLKS));
    check(16'(relN), 16'(1000 - 4 * irtcg_pkg::TICK_CLKS));
    check(16'(fastN), 16'(7 * irtcg_pkg::TICK_CLKS / 2));
    cpu.status(irtcg_pkg::STATUS_TIMER_ZERO);
    @(negedge mclk);
    check(statusFlag, 1'b1);
    cpu.set_halt(1'b0);
    // carrier burst ending inside a long high phase
    cpu.issue(irtcg_pkg::OP_WR10, irtcg_pkg::SEL_HIGH, 2'h0, 10'h03F);
    cpu.issue(irtcg_pkg::OP_WR10, irtcg_pkg::SEL_LOW, 2'h0, 10'h001);
    cpu.issue(irtcg_pkg::OP_WR10, irtcg_pkg::SEL_TIMER, 2'h0, 10'h201);
    prev = 1'b0;
    run = 0;
    highs = 0;
    lows = 0;
    for (int i = 0; i < 400; i++) begin
      @(negedge mclk);
      if (irOutput === prev) begin
        run++;
      end else begin
        if (prev === 1'b1) begin
          highs++;
          check(16'(run), 16'h0040);
        end else if (lows == 0) begin
          check(16'(run >= 2), 16'h0001);
        end else begin
          check(16'(run), 16'h0002);
        end
        lows += int'(prev === 1'b0);
        run = 1;
        prev = irOutput;
      end
    end
    check(16'(highs), 16'h0004);
    check(irOutput, 1'b0);
    // timer running with the output flag clear
    cpu.issue(irtcg_pkg::OP_WR10, irtcg_pkg::SEL_TIMER, 2'h0, 10'h002);
    repeat (20) begin
      @(negedge mclk);
      check({endOfOperation, irOutput, txIndicator_b}, 3'b001);
    end
    cpu.issue(irtcg_pkg::OP_WR10, irtcg_pkg::SEL_TIMER, 2'h0, 10'h000);
    @(negedge mclk);
    check(endOfOperation, 1'b1);
    cpu.issue(irtcg_pkg::OP_WRNIB, irtcg_pkg::SEL_TIMER, 2'h0, 10'h004);
    @(negedge mclk);
    check(endOfOperation, 1'b0);
    cpu.status(4'h3);
    @(negedge mclk);
    check(statusFlag, 1'b1);
    cpu.status(irtcg_pkg::STATUS_TIMER_ZERO);
    @(negedge mclk);
    check(statusFlag, 1'b0);
    // reset in mid-run
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check({endOfOperation, irOutput, txIndicator_b, statusFlag}, 4'hA);
    @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(negedge mclk);
    check({endOfOperation, irOutput, txIndicator_b, statusFlag}, 4'hA);
    cpu.issue(irtcg_pkg::OP_WR10, irtcg_pkg::SEL_TIMER, 2'h0, 10'h201);
    @(negedge mclk);
    check({endOfOperation, fastEnd}, 2'b00);
    check(stalled, 1'b0);
    give_verdict();
  end
endmodule : ir_timer_carrier_generator_bench

//--- tb/irtcg_cpu_model.sv
// cpu core stand-in issuing timer instructions, status tests and timer halts
`timescale 1ns/10ps
module irtcg_cpu_model (
  // clock
  input wire logic mclk,
  // from the block
  input wire logic irOutput,
  // to the block
  output irtcg_pkg::irtcg_cmd_t cmd,
  output logic statusTestValid,
  output logic [3:0] statusOperand,
  output logic haltWaitTimer,
  // width write held back too long
  output logic stalled
);
  initial begin
    cmd = '0;
    statusTestValid = 1'b0;
    statusOperand = 4'h0;
    haltWaitTimer = 1'b0;
    stalled = 1'b0;
  end

  // one instruction, valid for exactly one edge
  task automatic issue(input irtcg_pkg::irtcg_op_t op, input irtcg_pkg::irtcg_sel_t sel,
                       input logic [1:0] nib, input logic [9:0] d);
    int n;
    n = 0;
    // width registers only touched with the ir line low
    while (op != irtcg_pkg::OP_RD && sel != irtcg_pkg::SEL_TIMER && irOutput !== 1'b0) begin
      @(posedge mclk);
      n++;
      if (n > 5000) begin
        stalled = 1'b1;
        break;
      end
    end
    @(posedge mclk);
    cmd <= '{1'b1, op, sel, nib, d};
    @(posedge mclk);
    cmd <= '0;
  endtask : issue

  task automatic status(input logic [3:0] operand);
    @(posedge mclk);
    statusTestValid <= 1'b1;
    statusOperand <= operand;
    @(posedge mclk);
    statusTestValid <= 1'b0;
  endtask : status

  task automatic set_halt(input logic v);
    @(posedge mclk);
    haltWaitTimer <= v;
  endtask : set_halt
endmodule : irtcg_cpu_model
